// ==== shared/uctf_pkg.sv ====
package uctf_pkg;

   // ************************************************************
   // register indices on the plain register port
   // ************************************************************
   localparam logic [2:0] ADDR_DATA = 3'h0;
   localparam logic [2:0] ADDR_STAT_A = 3'h1;
   localparam logic [2:0] ADDR_CTRL_B = 3'h2;
   localparam logic [2:0] ADDR_CTRL_C = 3'h3;
   localparam logic [2:0] ADDR_BAUD_LO = 3'h4;
   localparam logic [2:0] ADDR_BAUD_HI = 3'h5;

   // ************************************************************
   // field positions
   // ************************************************************
   // status / control A
   localparam int A_RX_DONE = 7;
   localparam int A_TX_DONE = 6;
   localparam int A_BUF_EMPTY = 5;
   localparam int A_FRAME_ERR = 4;
   localparam int A_PAR_ERR = 2;
   localparam int A_DBL_SPEED = 1;
   // control B
   localparam int B_CLK_MASTER = 5;
   localparam int B_RX_EN = 4;
   localparam int B_TX_EN = 3;
   localparam int B_CHR_SZ2 = 2;
   localparam int B_RX_NINTH = 1;
   localparam int B_TX_NINTH = 0;
   // control C
   localparam int C_SYNC_MODE = 6;
   localparam int C_PAR_HI = 5;
   localparam int C_PAR_LO = 4;
   localparam int C_STOP2 = 3;
   localparam int C_CHR_HI = 2;
   localparam int C_CHR_LO = 1;
   localparam int C_CLK_POL = 0;

   // ************************************************************
   // reset values and timing counts
   // ************************************************************
   localparam logic [1:0] RST_PAR_MODE = 2'h0;
   localparam logic [1:0] RST_CHR_SZ = 2'h3;      // eight data bits after reset
   localparam logic [11:0] RST_BAUD = 12'h000;
   localparam logic [3:0] SAMPLES_NORMAL = 4'hF;  // last of 16 ticks per bit
   localparam logic [3:0] SAMPLES_DOUBLE = 4'h7;  // last of 8 ticks per bit
   localparam logic [3:0] MID_NORMAL = 4'h7;      // middle of start bit, 16 ticks
   localparam logic [3:0] MID_DOUBLE = 4'h3;      // middle of start bit, 8 ticks
   localparam logic [1:0] PAR_EVEN = 2'h2;
   localparam logic [1:0] PAR_ODD = 2'h3;
   localparam logic [2:0] CHR_NINE = 3'h7;

   // ************************************************************
   // types
   // ************************************************************
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } uctf_req_t;

   typedef enum logic [2:0] {
      TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP1, TX_STOP2
   } uctf_tx_state_t;

   typedef enum logic [2:0] {
      RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
   } uctf_rx_state_t;

endpackage : uctf_pkg

// ==== src/uctf_core.sv ====
// Overview of operation
// - double speed cuts divisor sixteen to eight
// - double speed receiver uses eight samples
// - double speed ignored in synchronous mode
// - slave clock synchronised then edge detected
// - sync mode: clock pin input or output
// - sync sample opposite edge to change
// - polarity zero: change rising, sample falling
// - all thirty frame formats supported
// - start, data LSB first, parity, stops
// - next frame follows or line idles high
// - receiver and transmitter share frame format
// - only first stop bit checked for error
// - parity is data XOR, inverted for odd
// - transmit enable takes over serial output
// - only sync master drives transfer clock pin
// - data write loads buffer, starts transmission
// - buffer moves to idle or finished shifter
// - unused upper data bits ignored
// - baud down-counter reloads, ticks at zero
// - transmitter divides ticks by 2/8/16
// - size code 7 selects nine bits
`timescale 1ns/1ps

module uctf_core (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   input wire uctf_pkg::uctf_req_t regReq,
   output logic [7:0] regRdata,
   // serial data pins
   input wire logic serialInPin,
   output logic serialOutPin,
   output logic serialOutOe,
   // transfer clock pin
   input wire logic xferClkIn,
   output logic xferClkOut,
   output logic xferClkOe
);
   import uctf_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [7:0] rdData;
      logic dblSpeed;
      logic txDoneF;
      logic rxDoneF;
      logic frameErrF;
      logic parErrF;
      logic rxEn;
      logic transmit_enable_bit;
      logic clkMaster;
      logic chrSz2;
      logic txNinth;
      logic syncMode;
      logic [1:0] parMode;
      logic stop2;
      logic [1:0] chrSz10;
      logic clkPol;
      logic [11:0] baud;
      logic [11:0] baudCnt;
      logic [3:0] txDiv;
      logic xckInt;
      logic xckS1;
      logic xckS2;
      logic xckS3;
      logic [8:0] bufData;
      logic bufFull;
      uctf_tx_state_t txSt;
      logic [8:0] txSh;
      logic [3:0] txBit;
      logic txPar;
      logic txOut;
      uctf_rx_state_t rxSt;
      logic [8:0] rxSh;
      logic [3:0] rxBit;
      logic [3:0] rxDiv;
      logic rxPar;
      logic [8:0] rxData;
   } uctf_state_t;

   uctf_state_t s_q;
   uctf_state_t s_d;

   // ************************************************************
   // decoded configuration
   // ************************************************************
   logic [2:0] chrCode;
   logic [3:0] nBits;
   logic dblEff;
   logic [3:0] bitLast;
   logic [3:0] midLast;
   logic baudTick;
   logic slvRise;
   logic slvFall;
   logic changeEv;
   logic sampleEv;
   logic txEv;
   logic rxSample;
   logic rxLine;
   logic txActive;

   // character size: 0..3 are 5..8 bits, 7 is nine, reserved codes run as eight
   always_comb begin
      chrCode = {s_q.chrSz2, s_q.chrSz10};
      case (chrCode)
         3'h0: nBits = 4'h5;
         3'h1: nBits = 4'h6;
         3'h2: nBits = 4'h7;
         CHR_NINE: nBits = 4'h9;
         default: nBits = 4'h8;
      endcase
   end

   // double speed only counts outside synchronous mode
   assign dblEff = s_q.dblSpeed & ~s_q.syncMode;
   assign bitLast = dblEff ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
   assign midLast = dblEff ? MID_DOUBLE : MID_NORMAL;
   assign baudTick = (s_q.baudCnt == 12'h000);

   // slave clock edges come off the second and third stages only
   assign slvRise = s_q.xckS2 & ~s_q.xckS3;
   assign slvFall = ~s_q.xckS2 & s_q.xckS3;

   // master: internal rise is the change edge; the pin is flipped by polarity
   always_comb begin
      if (s_q.clkMaster) begin
         changeEv = baudTick & ~s_q.xckInt;
         sampleEv = baudTick & s_q.xckInt;
      end else begin
         changeEv = s_q.clkPol ? slvFall : slvRise;
         sampleEv = s_q.clkPol ? slvRise : slvFall;
      end
   end

   assign txEv = s_q.syncMode ? changeEv : (baudTick && s_q.txDiv == bitLast);
   assign rxLine = serialInPin;
   assign rxSample = s_q.syncMode ? sampleEv
                     : (baudTick && s_q.rxDiv == ((s_q.rxSt == RX_START) ? midLast : bitLast));
   // a disabled transmitter keeps the pin until pending work is out
   assign txActive = s_q.transmit_enable_bit | s_q.bufFull | (s_q.txSt != TX_IDLE);

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      s_d = s_q;

      // register writes
      if (regReq.wr) begin
         case (regReq.addr)
            ADDR_DATA: begin
               if (!s_q.bufFull) begin
                  // upper bits beyond the character are dropped at send time
                  s_d.bufData = {s_q.txNinth, regReq.wdata};
                  s_d.bufFull = 1'b1;
               end
            end
            ADDR_STAT_A: begin
               s_d.dblSpeed = regReq.wdata[A_DBL_SPEED];
               if (regReq.wdata[A_TX_DONE]) begin
                  s_d.txDoneF = 1'b0;
               end
            end
            ADDR_CTRL_B: begin
               s_d.clkMaster = regReq.wdata[B_CLK_MASTER];
               s_d.rxEn = regReq.wdata[B_RX_EN];
               s_d.transmit_enable_bit = regReq.wdata[B_TX_EN];
               s_d.chrSz2 = regReq.wdata[B_CHR_SZ2];
               s_d.txNinth = regReq.wdata[B_TX_NINTH];
            end
            ADDR_CTRL_C: begin
               s_d.syncMode = regReq.wdata[C_SYNC_MODE];
               s_d.parMode = regReq.wdata[C_PAR_HI:C_PAR_LO];
               s_d.stop2 = regReq.wdata[C_STOP2];
               s_d.chrSz10 = regReq.wdata[C_CHR_HI:C_CHR_LO];
               s_d.clkPol = regReq.wdata[C_CLK_POL];
            end
            ADDR_BAUD_HI: begin
               s_d.baud[11:8] = regReq.wdata[3:0];
            end
            default: begin
               s_d.baud[7:0] = (regReq.addr == ADDR_BAUD_LO) ? regReq.wdata : s_q.baud[7:0];
            end
         endcase
      end

      // register reads, answered one cycle later
      s_d.rdData = 8'h00;
      if (regReq.rd) begin
         case (regReq.addr)
            ADDR_DATA: begin
               s_d.rdData = s_q.rxData[7:0];
               s_d.rxDoneF = 1'b0;
            end
            ADDR_STAT_A: begin
               s_d.rdData[A_RX_DONE] = s_q.rxDoneF;
               s_d.rdData[A_TX_DONE] = s_q.txDoneF;
               s_d.rdData[A_BUF_EMPTY] = ~s_q.bufFull;
               s_d.rdData[A_FRAME_ERR] = s_q.frameErrF;
               s_d.rdData[A_PAR_ERR] = s_q.parErrF;
               s_d.rdData[A_DBL_SPEED] = s_q.dblSpeed;
            end
            ADDR_CTRL_B: begin
               s_d.rdData[B_CLK_MASTER] = s_q.clkMaster;
               s_d.rdData[B_RX_EN] = s_q.rxEn;
               s_d.rdData[B_TX_EN] = s_q.transmit_enable_bit;
               s_d.rdData[B_CHR_SZ2] = s_q.chrSz2;
               s_d.rdData[B_RX_NINTH] = s_q.rxData[8];
               s_d.rdData[B_TX_NINTH] = s_q.txNinth;
            end
            ADDR_CTRL_C: begin
               s_d.rdData[C_SYNC_MODE] = s_q.syncMode;
               s_d.rdData[C_PAR_HI:C_PAR_LO] = s_q.parMode;
               s_d.rdData[C_STOP2] = s_q.stop2;
               s_d.rdData[C_CHR_HI:C_CHR_LO] = s_q.chrSz10;
               s_d.rdData[C_CLK_POL] = s_q.clkPol;
            end
            ADDR_BAUD_LO: s_d.rdData = s_q.baud[7:0];
            ADDR_BAUD_HI: s_d.rdData = {4'h0, s_q.baud[11:8]};
            default: s_d.rdData = 8'h00;
         endcase
      end

      // baud down-counter; a low-byte write restarts it at once
      if (regReq.wr && regReq.addr == ADDR_BAUD_LO) begin
         s_d.baudCnt = {s_q.baud[11:8], regReq.wdata};
      end else if (baudTick) begin
         s_d.baudCnt = s_q.baud;
      end else begin
         s_d.baudCnt = s_q.baudCnt - 12'h001;
      end

      // transmit tick divider and master clock
      if (baudTick) begin
         s_d.txDiv = (s_q.txDiv >= bitLast) ? 4'h0 : s_q.txDiv + 4'h1;
         s_d.xckInt = s_q.syncMode & s_q.clkMaster & ~s_q.xckInt;
      end

      // slave clock synchroniser and edge history
      s_d.xckS1 = xferClkIn;
      s_d.xckS2 = s_q.xckS1;
      s_d.xckS3 = s_q.xckS2;

      // ********************************************************
      // transmitter
      // ********************************************************
      if (s_q.txSt == TX_IDLE) begin
         s_d.txOut = 1'b1;
         if (s_q.bufFull && s_q.transmit_enable_bit) begin
            s_d.txSh = s_q.bufData;
            s_d.bufFull = 1'b0;
            s_d.txSt = TX_START;
         end
      end else if (txEv) begin
         case (s_q.txSt)
            TX_START: begin
               s_d.txOut = 1'b0;
               s_d.txBit = 4'h0;
               s_d.txPar = 1'b0;
               s_d.txSt = TX_DATA;
            end
            TX_DATA: begin
               s_d.txOut = s_q.txSh[s_q.txBit];
               s_d.txPar = s_q.txPar ^ s_q.txSh[s_q.txBit];
               s_d.txBit = s_q.txBit + 4'h1;
               if (s_q.txBit == nBits - 4'h1) begin
                  s_d.txSt = s_q.parMode[1] ? TX_PAR : TX_STOP1;
               end
            end
            TX_PAR: begin
               s_d.txOut = s_q.txPar ^ (s_q.parMode == PAR_ODD);
               s_d.txSt = TX_STOP1;
            end
            TX_STOP1: begin
               s_d.txOut = 1'b1;
               s_d.txSt = s_q.stop2 ? TX_STOP2 : TX_IDLE;
            end
            TX_STOP2: begin
               s_d.txOut = 1'b1;
               s_d.txSt = TX_IDLE;
            end
            default: s_d.txSt = TX_IDLE;
         endcase
      end

      // a finished frame hands straight to a waiting buffer
      if (s_q.txSt != TX_IDLE && s_d.txSt == TX_IDLE && txEv) begin
         if (s_q.bufFull) begin
            s_d.txSh = s_q.bufData;
            s_d.bufFull = 1'b0;
            s_d.txSt = TX_START;
         end else begin
            s_d.txDoneF = 1'b1; // set wins over a same-cycle clear
         end
      end
      // buffer refill that coincides with the hand-over keeps the new word
      if (regReq.wr && regReq.addr == ADDR_DATA && s_q.bufFull && s_d.bufFull == 1'b0) begin
         s_d.bufData = {s_q.txNinth, regReq.wdata};
         s_d.bufFull = 1'b1;
      end

      // ********************************************************
      // receiver, same format fields as the transmitter
      // ********************************************************
      if (baudTick && !s_q.syncMode) begin
         s_d.rxDiv = (s_q.rxDiv >= bitLast) ? 4'h0 : s_q.rxDiv + 4'h1;
      end
      if (!s_q.rxEn) begin
         s_d.rxSt = RX_IDLE;
      end else begin
         case (s_q.rxSt)
            RX_IDLE: begin
               s_d.rxSh = 9'h000;
               s_d.rxBit = 4'h0;
               s_d.rxPar = 1'b0;
               if (s_q.syncMode) begin
                  if (sampleEv && !rxLine) begin
                     s_d.rxSt = RX_DATA;
                  end
               end else if (!rxLine) begin
                  s_d.rxDiv = 4'h0;
                  s_d.rxSt = RX_START;
               end
            end
            RX_START: begin
               if (rxSample) begin
                  s_d.rxDiv = 4'h0;
                  // a start bit gone high at mid-bit was only a glitch
                  s_d.rxSt = rxLine ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rxSample) begin
                  s_d.rxSh[s_q.rxBit] = rxLine;
                  s_d.rxPar = s_q.rxPar ^ rxLine;
                  s_d.rxBit = s_q.rxBit + 4'h1;
                  if (s_q.rxBit == nBits - 4'h1) begin
                     s_d.rxSt = s_q.parMode[1] ? RX_PAR : RX_STOP;
                  end
               end
            end
            RX_PAR: begin
               if (rxSample) begin
                  s_d.rxPar = s_q.rxPar ^ rxLine ^ (s_q.parMode == PAR_ODD);
                  s_d.rxSt = RX_STOP;
               end
            end
            RX_STOP: begin
               // only the first stop bit is looked at; a second passes as idle
               if (rxSample) begin
                  s_d.frameErrF = ~rxLine;
                  s_d.parErrF = s_q.rxPar;
                  s_d.rxData = s_q.rxSh;
                  s_d.rxDoneF = 1'b1; // set wins over a same-cycle read
                  s_d.rxSt = RX_IDLE;
               end
            end
            default: s_d.rxSt = RX_IDLE;
         endcase
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_q <= '0;
         s_q.chrSz10 <= RST_CHR_SZ;
         s_q.parMode <= RST_PAR_MODE;
         s_q.baud <= RST_BAUD;
         s_q.baudCnt <= RST_BAUD;
         s_q.txSt <= TX_IDLE;
         s_q.rxSt <= RX_IDLE;
         s_q.txOut <= 1'b1;
         s_q.rxSh <= 9'h000;
      end else begin
         s_q <= s_d;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign regRdata = s_q.rdData;
   assign serialOutPin = s_q.txOut;
   assign serialOutOe = txActive;
   assign xferClkOut = s_q.xckInt ^ s_q.clkPol;
   // master drives the pin only in sync mode; transmit use has no effect on it
   assign xferClkOe = s_q.syncMode & s_q.clkMaster;

endmodule : uctf_core

// ==== verification/tb.sv ====
`timescale 1ns/1ps

module tb;
   import uctf_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   uctf_req_t regReq = '0;
   logic [7:0] regRdata, got;
   logic serialInPin, serialOutPin, serialOutOe, xferClkOut, xferClkOe;
   logic xferClkIn = 1'b0;
   logic slvClk = 1'b0;
   logic [15:0] bitCycles = 16'h0010;
   logic [3:0] frameBits = 4'hA;
   logic [15:0] expQ[$];
   logic [7:0] seed = 8'h04;
   logic [2:0] resAddr[4] = '{ADDR_STAT_A, ADDR_CTRL_B, ADDR_CTRL_C, 3'h6};
   logic [7:0] resVal[4] = '{8'h20, 8'h00, 8'h06, 8'h00};
   int n_mismatch = 0;
   int compares = 0;

   always #12.5 mclk = ~mclk;

   // slave clock at an eighth of mclk, well inside what the sync stages can follow
   always begin
      repeat (4) @(posedge mclk);
      if (slvClk) begin
         xferClkIn <= ~xferClkIn;
      end
   end

   uctf_core dut_u (.mclk(mclk), .rst(rst), .regReq(regReq), .regRdata(regRdata),
      .serialInPin(serialInPin), .serialOutPin(serialOutPin), .serialOutOe(serialOutOe),
      .xferClkIn(xferClkIn), .xferClkOut(xferClkOut), .xferClkOe(xferClkOe));
   uctf_far_end far_u (.mclk(mclk), .serialOutPin(serialOutPin), .serialOutOe(serialOutOe),
      .bitCycles(bitCycles), .frameBits(frameBits), .serialInPin(serialInPin));

   // ******
   // helpers
   // ******
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   // expected line bits: start, data lsb first, parity, stops (ones above)
   function automatic logic [15:0] frameOf(input logic [8:0] d, input int n, input int par);
      logic [15:0] f;
      f = '1;
      f[0] = 1'b0;
      for (int i = 0; i < n; i++) begin
         f[i + 1] = d[i];
      end
      if (par != 0) begin
         f[n + 1] = ^(32'(d) & ((32'h1 << n) - 1)) ^ (par == 3);
      end
      return f;
   endfunction : frameOf

   task automatic check(input logic [15:0] g, input logic [15:0] e, input string what);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, g, e);
      end
   endtask : check

   // strobe is dropped at the taking edge; 1 ns later the next request may start
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      regReq <= '0;
      #1;
   endtask : wr

   task automatic rd(input logic [2:0] a);
      regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      regReq <= '0;
      #1;
      got = regRdata;
   endtask : rd

   task automatic timeout();
      n_mismatch++;
      $display("CHECK FAILED t=%0t wait ran out", $time);
      summarize();
   endtask : timeout

   // poll a status bit until set, bounded
   task automatic waitSet(input int b);
      int k = 0;
      do begin
         rd(ADDR_STAT_A);
         k++;
      end while (got[b] !== 1'b1 && k < 3000);
      if (k >= 3000) begin
         timeout();
      end
   endtask : waitSet

   // done rises as the last stop bit starts; the far end takes it at mid-bit
   task automatic waitFrames(input int cnt);
      int k = 0;
      while (far_u.rxQ.size() < cnt && k < 2000) begin
         @(posedge mclk);
         k++;
      end
      if (far_u.rxQ.size() != cnt) begin
         timeout();
      end
   endtask : waitFrames

   task automatic summarize();
      if (n_mismatch == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize

   // ******
   // main sequence
   // ******
   initial begin
      int n, par, k;
      logic [2:0] code;
      logic two, dbl;
      logic [1:0] baud;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1;
      wr(3'h6, 8'hFF);
      foreach (resAddr[i]) begin
         rd(resAddr[i]);
         check(16'(got), 16'(resVal[i]), "reset value");
      end
      // every frame format, alternating speed and divisor
      for (int f = 0; f < 30; f++) begin
         code = (f % 5 == 4) ? 3'h7 : 3'(f % 5);
         n = (code == 3'h7) ? 9 : 5 + f % 5;
         par = (f / 5 % 3 == 0) ? 0 : 1 + f / 5 % 3;
         two = 1'(f / 15);
         dbl = 1'(f % 2);
         baud = 2'(f % 3);
         bitCycles <= 16'((int'(baud) + 1) * (dbl ? 8 : 16));
         frameBits <= 4'(2 + n + (par != 0) + two);
         wr(ADDR_BAUD_HI, 8'h00);
         wr(ADDR_BAUD_LO, {6'h00, baud});
         wr(ADDR_STAT_A, {6'h00, dbl, 1'b0});
         wr(ADDR_CTRL_C, {2'h0, 2'(par), two, code[1:0], 1'b0});
         // second write lands while the first frame shifts out
         for (int j = 0; j < 2; j++) begin
            seed = lfsr(seed);
            wr(ADDR_CTRL_B, {4'h0, 1'b1, code[2], 1'b0, seed[2]});
            wr(ADDR_DATA, seed);
            expQ.push_back(frameOf({seed[2], seed}, n, par));
            waitSet(A_BUF_EMPTY);
         end
         waitSet(A_TX_DONE);
         waitFrames(2);
         while (far_u.rxQ.size() > 0) begin
            check(far_u.rxQ.pop_front(), expQ.pop_front(), "frame bits");
         end
         wr(ADDR_STAT_A, {1'b0, 1'b1, 4'h0, dbl, 1'b0});
         rd(ADDR_STAT_A);
         check(16'(got[A_TX_DONE]), 16'h0, "done not cleared");
         // transmitter off, so the next format starts from a released pin
         wr(ADDR_CTRL_B, 8'h00);
      end
      // receive: two stop bits set, only the first is judged
      wr(ADDR_STAT_A, 8'h00);
      wr(ADDR_BAUD_LO, 8'h00);
      wr(ADDR_CTRL_C, 8'h0E);
      wr(ADDR_CTRL_B, 8'h18);
      for (k = 0; k < 2; k++) begin
         far_u.send({5'h1F, k == 0, 8'hA5 ^ 8'(k), 1'b0}, 10 + k, 16);
         rd(ADDR_STAT_A);
         check(16'({got[A_RX_DONE], got[A_FRAME_ERR]}), 16'({1'b1, k == 1}), "rx status");
         rd(ADDR_DATA);
         check(16'(got), 16'(8'hA5 ^ 8'(k)), "rx data");
      end
      // synchronous 8N1 frames: slave on the bench clock, then master
      frameBits <= 4'hA;
      wr(ADDR_CTRL_C, 8'h46);
      for (int m = 0; m < 2; m++) begin
         slvClk <= (m == 0);
         bitCycles <= (m == 0) ? 16'h0008 : 16'h0002;
         wr(ADDR_CTRL_B, (m == 0) ? 8'h08 : 8'h28);
         if (m == 1) begin
            check(16'(xferClkOe), 16'h1, "clock pin not driven");
            got[0] = xferClkOut;
            @(posedge mclk);
            #1;
            check(16'(xferClkOut), 16'(!got[0]), "master clock stuck");
         end
         seed = lfsr(seed);
         wr(ADDR_DATA, seed);
         waitSet(A_TX_DONE);
         waitFrames(1);
         check(far_u.rxQ.pop_front(), frameOf({1'b0, seed}, 8, 0), "sync frame");
         wr(ADDR_STAT_A, 8'h40);
      end
      summarize();
   end
endmodule : tb

// ==== verification/uctf_core_properties.sv ====
`timescale 1ns/1ps

module uctf_core_properties
   import uctf_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // register port
   input wire uctf_pkg::uctf_req_t regReq,
   input wire logic [7:0] regRdata,
   // pins
   input wire logic serialInPin,
   input wire logic serialOutPin,
   input wire logic serialOutOe,
   input wire logic xferClkIn,
   input wire logic xferClkOut,
   input wire logic xferClkOe
);
   logic transmit_enable_bit_q, master_q, sync_q, dbl_q, pol_q, prevPin_q;
   logic [11:0] baud_q;
   int runLen_q;
   logic dataWr;
   int bitLen;

   // ******
   // shadow of the mode bits, updated on the same edge as the design
   // ******
   assign dataWr = regReq.wr && regReq.addr == ADDR_DATA;
   assign bitLen = (int'(baud_q) + 1) * (dbl_q ? 8 : 16);
   always_ff @(posedge mclk) begin
      if (rst) begin
         {transmit_enable_bit_q, master_q, sync_q, dbl_q, pol_q} <= 5'h00;
         baud_q <= RST_BAUD;
      end else if (regReq.wr) begin
         case (regReq.addr)
            ADDR_STAT_A: dbl_q <= regReq.wdata[A_DBL_SPEED];
            ADDR_CTRL_B: begin
               transmit_enable_bit_q <= regReq.wdata[B_TX_EN];
               master_q <= regReq.wdata[B_CLK_MASTER];
            end
            ADDR_CTRL_C: begin
               sync_q <= regReq.wdata[C_SYNC_MODE];
               pol_q <= regReq.wdata[C_CLK_POL];
            end
            ADDR_BAUD_LO: baud_q[7:0] <= regReq.wdata;
            ADDR_BAUD_HI: baud_q[11:8] <= regReq.wdata[3:0];
            default: ;
         endcase
      end
   end
   // length of the current run of one level on the line
   always_ff @(posedge mclk) begin
      prevPin_q <= serialOutPin;
      runLen_q <= (serialOutPin != prevPin_q) ? 1 : runLen_q + 1;
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_read_zero: assert property (!$past(regReq.rd) |-> regRdata == 8'h00)
      else $error("read data outside its cycle");
   a_reset_quiet: assert property (disable iff (1'b0) rst |=> serialOutPin && !serialOutOe && !xferClkOe)
      else $error("pins not quiet after reset");
   a_idle_high: assert property (!serialOutOe |-> serialOutPin)
      else $error("line not high while idle");
   a_start_owned: assert property ($fell(serialOutPin) |-> serialOutOe)
      else $error("line low without ownership");
   a_write_owns: assert property (dataWr && transmit_enable_bit_q |=> serialOutOe)
      else $error("data write did not take the line");
   // the pin was released the cycle before, so this write meets an idle shifter
   a_start_soon: assert property (dataWr && transmit_enable_bit_q && !$past(serialOutOe) && !sync_q
      && baud_q == 12'h000 |-> ##[1:40] !serialOutPin)
      else $error("start bit late");
   a_low_run: assert property ($rose(serialOutPin) && serialOutOe && !sync_q
      |-> runLen_q % bitLen == 0)
      else $error("bit period wrong");
   a_master_oe: assert property (xferClkOe == (sync_q && master_q))
      else $error("clock pin direction wrong");
   // master: data moves only with the clock edge that polarity names as change edge
   a_change_edge: assert property ($changed(serialOutPin) && xferClkOe
      |-> $changed(xferClkOut) && xferClkOut != pol_q)
      else $error("data changed on the wrong clock edge");

   // main scenarios
   c_data_write: cover property (dataWr && serialOutOe);
   c_double: cover property ($rose(serialOutPin) && dbl_q);
   c_master: cover property (xferClkOe);
endmodule : uctf_core_properties

bind uctf_core uctf_core_properties chk_u (.mclk(mclk), .rst(rst), .regReq(regReq),
   .regRdata(regRdata), .serialInPin(serialInPin), .serialOutPin(serialOutPin),
   .serialOutOe(serialOutOe), .xferClkIn(xferClkIn), .xferClkOut(xferClkOut),
   .xferClkOe(xferClkOe));

// ==== verification/uctf_far_end.sv ====
`timescale 1ns/1ps

module uctf_far_end (
   // clock
   input wire logic mclk,
   // line from the block
   input wire logic serialOutPin,
   input wire logic serialOutOe,
   // frame shape chosen by the bench
   input wire logic [15:0] bitCycles,
   input wire logic [3:0] frameBits,
   // line to the block
   output logic serialInPin
);
   logic [15:0] rxQ[$];
   logic [15:0] frm;

   initial serialInPin = 1'b1;

   // ******
   // capture: sample each bit at its middle, no wait after the last one
   // ******
   // stopping at mid last stop lets a back-to-back start edge be caught
   always begin
      @(negedge serialOutPin iff serialOutOe);
      frm = '1;
      repeat (bitCycles / 2) @(posedge mclk);
      for (int i = 0; i < frameBits; i++) begin
         if (i > 0) begin
            repeat (bitCycles) @(posedge mclk);
         end
         frm[i] = serialOutPin;
      end
      rxQ.push_back(frm);
   end

   // send bits lsb first, then return the line to idle high
   task automatic send(input logic [15:0] bits, input int n, input int cyc);
      for (int i = 0; i < n; i++) begin
         serialInPin <= bits[i];
         repeat (cyc) @(posedge mclk);
      end
      serialInPin <= 1'b1;
   endtask : send
endmodule : uctf_far_end
